// ---- rtl/acst_map.svh ----
/*
 constants of the converter serial interface sequencer.
 assumes a 200 MHz system clock; included by the sequencer top module only.
*/
// Summary of operation
// - external clock: sample address input on first 8 rising edges, update output on falling.
// - external clock: output goes high on 19th falling edge, new conversion.
// - internal clock chosen if clock pin high at chip-select fall or at end of power-on reset.
// - pull-up on clock pin stays active across chip-select fall.
// - data output high impedance whenever chip select is high.
// - internal clock: on select fall drive clock low, show busy flag.
// - status test with conversion done wakes device; host raises select early.
// - internal clock: first rising edge a status-test delay after ready.
// - select rising within test delay returns to sleep, result kept.
// - internal clock: generate 19 pulses, shift out falling, sample rising.
// - after 19th internal rising edge: output high, clock high, convert.
// - select rising during transfer aborts it and starts conversion at once.
// - aborted before last address bit: old channel address kept.
// - pull-up off while clock pin low; stays low after such abort.
// - status pulse in sleep: pull-up restored when select rises early.
// - select grounded: clock mode latched at end of power-on reset.
// - continuous mode: sleep half a clock period, then start output.
// - continuous mode: after 19th rise output high, clock high converting.
// - clock pin low at select fall selects external clock mode.
`ifndef ACST_MAP_SVH
`define ACST_MAP_SVH
`define ACST_CLK_MHZ 200
`define ACST_TEST_DELAY_NS 23000
`define ACST_TEST_CYC ((`ACST_TEST_DELAY_NS * `ACST_CLK_MHZ + 999) / 1000)
`define ACST_EXT_TEST_X10 36
`define ACST_EOSC_KHZ 300
`define ACST_POR_US 1000
`define ACST_POR_CYC (`ACST_POR_US * `ACST_CLK_MHZ)
`define ACST_SCK_HALF 16
`define ACST_XFER_BITS 5'd19
`define ACST_RES_W 18
`define ACST_ADDR_W 8
`endif

// ---- rtl/acst_pkg.sv ----
/*
 types of the converter serial interface sequencer.
 assumes nothing of its surroundings.
*/
package acst_pkg;
    typedef enum logic [2:0] {
        ST_POR,
        ST_IDLE,
        ST_STATUS,
        ST_XFER,
        ST_CONT_CONV,
        ST_CONT_SLEEP
    } acst_state_t;
endpackage : acst_pkg

// ---- rtl/acst_sync.sv ----
/*
 two flip-flop synchroniser for pin inputs.
 assumes inputs asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module acst_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
)
(
    input wire logic clk_sys, // system clock
    input wire logic reset, // sync, active high
    input wire logic [W-1:0] d, // raw pin levels
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            meta_reg <= RST;
            q_reg <= RST;
        end
        else
        begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule : acst_sync
`default_nettype wire

// ---- rtl/acst_top.sv ----
/*
 serial interface sequencer of a multiplexed converter: clock mode
 selection, status test, 19-edge transfer, abort, continuous mode.
 assumes converter core on clk_sys; pins are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acst_map.svh"
module acst_top
    import acst_pkg::*;
#(
    parameter int POR_CYC = `ACST_POR_CYC,
    parameter int TEST_CYC = `ACST_TEST_CYC,
    parameter int EOSC_KHZ = `ACST_EOSC_KHZ,
    parameter int SCK_HALF = `ACST_SCK_HALF,
    parameter int RES_W = `ACST_RES_W,
    parameter int ADDR_W = `ACST_ADDR_W
)
(
    input wire logic clk_sys, // 200 MHz system clock
    input wire logic reset, // sync, active high
    input wire logic cs_n, // chip select pin
    input wire logic sck_in, // clock pin level
    output logic sck_out, // clock pin drive value
    output logic sck_oe_n, // clock pin driven when low
    output logic sck_pu_en, // weak pull-up enable
    input wire logic sdi, // serial data in pin
    output logic sdo_out, // serial data out value
    output logic sdo_oe_n, // data out driven when low
    input wire logic ext_osc, // core runs on external osc
    input wire logic conv_done, // core: conversion finished
    input wire logic [RES_W-1:0] conv_result, // core result
    output logic conv_start, // core: start conversion
    output logic [ADDR_W-1:0] chan_addr // stored channel address
);
    // ----------------------------------------
    // constants and state
    // ----------------------------------------
    localparam int EXT_TEST_CYC =
        (`ACST_EXT_TEST_X10 * `ACST_CLK_MHZ * 100 + EOSC_KHZ - 1)
        / EOSC_KHZ;
    localparam logic [4:0] ADDR_LAST = 5'(ADDR_W);

    typedef struct packed {
        acst_state_t st;
        logic int_mode;
        logic cont_mode;
        logic busy;
        logic cs_q;
        logic sck_q;
        logic [31:0] tmr;
        logic [4:0] bits;
        logic [RES_W:0] sreg;
        logic [ADDR_W-1:0] ash;
        logic [ADDR_W-1:0] addr;
        logic sck_drv;
        logic sck_lvl;
        logic sdo;
        logic sdo_oe_n;
        logic pu;
        logic restore;
        logic conv_start;
    } acst_st_t;

    localparam acst_st_t RST_ST = '{st: ST_POR, cs_q: 1'b1,
        sck_q: 1'b1, sck_lvl: 1'b1, sdo_oe_n: 1'b1, pu: 1'b1,
        default: '0};

    acst_st_t s_reg;
    acst_st_t s_next;
    logic cs_s;
    logic sck_s;
    logic sdi_s;
    logic sck_rise;
    logic sck_fall;
    logic converting;
    logic [31:0] test_cyc;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    acst_sync #(
        .W(3),
        .RST(3'h6)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .d({cs_n, sck_in, sdi}),
        .q({cs_s, sck_s, sdi_s})
    );

    assign sck_rise = sck_s & ~s_reg.sck_q;
    assign sck_fall = ~sck_s & s_reg.sck_q;
    assign converting = s_reg.busy | s_reg.conv_start;
    assign test_cyc = ext_osc ? 32'(EXT_TEST_CYC) : 32'(TEST_CYC);

    // ----------------------------------------
    // shift helpers
    // ----------------------------------------
    // rising edge: take address bit, count the edge
    function automatic acst_st_t on_rise(acst_st_t x, logic d);
        if (x.bits < ADDR_LAST)
        begin
            x.ash = {x.ash[ADDR_W-2:0], d};
            if (x.bits == ADDR_LAST - 5'd1)
            begin
                x.addr = x.ash;
            end
        end
        x.bits = x.bits + 5'd1;
        return x;
    endfunction : on_rise

    // falling edge: next result bit to the output
    function automatic acst_st_t on_fall(acst_st_t x);
        x.sreg = {x.sreg[RES_W-1:0], 1'b0};
        return x;
    endfunction : on_fall

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.cs_q = cs_s;
        s_next.sck_q = sck_s;
        s_next.conv_start = 1'b0;
        if (s_reg.conv_start)
        begin
            s_next.busy = 1'b1;
        end
        else if (conv_done && s_reg.busy)
        begin
            s_next.busy = 1'b0;
            s_next.sreg = {1'b0, conv_result};
        end
        case (s_reg.st)
            ST_POR:
            begin
                s_next.tmr = s_reg.tmr + 32'd1;
                if (s_reg.tmr == 32'(POR_CYC - 1))
                begin
                    s_next.tmr = '0;
                    s_next.conv_start = 1'b1;
                    s_next.int_mode = sck_s;
                    s_next.cont_mode = sck_s & ~cs_s;
                    if (cs_s)
                    begin
                        s_next.st = ST_IDLE;
                    end
                    else if (sck_s)
                    begin
                        s_next.st = ST_CONT_CONV;
                    end
                    else
                    begin
                        s_next.st = ST_STATUS;
                    end
                end
            end
            ST_IDLE:
            begin
                s_next.sck_drv = 1'b0;
                s_next.tmr = '0;
                s_next.bits = '0;
                if (!cs_s && s_reg.cs_q)
                begin
                    s_next.int_mode = sck_s;
                    s_next.cont_mode = 1'b0;
                    s_next.restore = 1'b0;
                    s_next.st = ST_STATUS;
                    if (sck_s)
                    begin
                        s_next.sck_drv = 1'b1;
                        s_next.sck_lvl = 1'b0;
                    end
                end
            end
            ST_STATUS:
            begin
                if (cs_s)
                begin
                    // early rise: back to sleep, result untouched
                    s_next.st = ST_IDLE;
                    s_next.sck_drv = 1'b0;
                    if (s_reg.int_mode && !converting)
                    begin
                        s_next.restore = 1'b1;
                    end
                end
                else if (s_reg.int_mode)
                begin
                    if (converting)
                    begin
                        s_next.tmr = '0;
                    end
                    else
                    begin
                        s_next.sck_lvl = 1'b0;
                        s_next.tmr = s_reg.tmr + 32'd1;
                        if (s_reg.tmr == test_cyc - 32'd1)
                        begin
                            s_next.tmr = '0;
                            s_next.sck_lvl = 1'b1;
                            s_next.st = ST_XFER;
                            s_next = on_rise(s_next, sdi_s);
                        end
                    end
                end
                else if (sck_rise && !converting)
                begin
                    s_next.st = ST_XFER;
                    s_next = on_rise(s_next, sdi_s);
                end
            end
            ST_XFER:
            begin
                if (cs_s && !s_reg.cont_mode)
                begin
                    s_next.st = ST_IDLE;
                    s_next.sck_drv = 1'b0;
                    s_next.conv_start = 1'b1;
                    s_next.bits = '0;
                end
                else if (s_reg.int_mode)
                begin
                    s_next.tmr = s_reg.tmr + 32'd1;
                    if (s_reg.tmr == 32'(SCK_HALF - 1))
                    begin
                        s_next.tmr = '0;
                        if (!s_reg.sck_lvl)
                        begin
                            s_next.sck_lvl = 1'b1;
                            s_next = on_rise(s_next, sdi_s);
                        end
                        else if (s_reg.bits == `ACST_XFER_BITS)
                        begin
                            s_next.conv_start = 1'b1;
                            s_next.bits = '0;
                            s_next.st = s_reg.cont_mode ? ST_CONT_CONV
                                                        : ST_STATUS;
                        end
                        else
                        begin
                            s_next.sck_lvl = 1'b0;
                            s_next = on_fall(s_next);
                        end
                    end
                end
                else if (sck_rise)
                begin
                    s_next = on_rise(s_next, sdi_s);
                end
                else if (sck_fall)
                begin
                    if (s_reg.bits == `ACST_XFER_BITS)
                    begin
                        s_next.conv_start = 1'b1;
                        s_next.bits = '0;
                        s_next.st = ST_STATUS;
                    end
                    else
                    begin
                        s_next = on_fall(s_next);
                    end
                end
            end
            ST_CONT_CONV:
            begin
                s_next.sck_drv = 1'b1;
                s_next.sck_lvl = 1'b1;
                s_next.tmr = '0;
                if (!converting)
                begin
                    s_next.sck_lvl = 1'b0;
                    s_next.st = ST_CONT_SLEEP;
                end
            end
            ST_CONT_SLEEP:
            begin
                s_next.tmr = s_reg.tmr + 32'd1;
                if (s_reg.tmr == 32'(SCK_HALF - 1))
                begin
                    s_next.tmr = '0;
                    s_next.sck_lvl = 1'b1;
                    s_next.st = ST_XFER;
                    s_next = on_rise(s_next, sdi_s);
                end
            end
            default:
            begin
                s_next.st = ST_POR;
            end
        endcase
        // output pins follow the current state
        s_next.sdo_oe_n = cs_s;
        s_next.sdo = (s_reg.st == ST_XFER) ? s_reg.sreg[RES_W]
                                           : converting;
        if (sck_s)
        begin
            s_next.restore = 1'b0;
        end
        s_next.pu = (s_reg.st == ST_POR) | sck_s
                  | s_next.restore;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s_reg <= RST_ST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign sck_out = s_reg.sck_lvl;
    assign sck_oe_n = ~s_reg.sck_drv;
    assign sck_pu_en = s_reg.pu;
    assign sdo_out = s_reg.sdo;
    assign sdo_oe_n = s_reg.sdo_oe_n;
    assign conv_start = s_reg.conv_start;
    assign chan_addr = s_reg.addr;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence ext_last_fall;
        s_reg.st == ST_XFER && !s_reg.int_mode && !cs_s && sck_fall
            && s_reg.bits == `ACST_XFER_BITS;
    endsequence
    sequence int_last_high;
        s_reg.st == ST_XFER && s_reg.int_mode && !cs_s
            && s_reg.sck_lvl && s_reg.bits == `ACST_XFER_BITS
            && s_reg.tmr == 32'(SCK_HALF - 1);
    endsequence
    sequence xfer_abort;
        s_reg.st == ST_XFER && cs_s && !s_reg.cont_mode;
    endsequence

    sdo_hiz_a: assert property (cs_s |=> sdo_oe_n)
        else $error("data output driven while select high");
    int_select_a: assert property (s_reg.st == ST_IDLE && !cs_s
        && s_reg.cs_q && sck_s |=> !sck_oe_n && !sck_out)
        else $error("clock pin not driven low at select fall");
    ext_end_a: assert property (ext_last_fall |=> conv_start
        ##[1:2] sdo_out)
        else $error("no conversion or high output after 19th fall");
    int_end_a: assert property (int_last_high |=> conv_start
        && !sck_oe_n && sck_out ##1 sdo_out)
        else $error("bad end of internal transfer");
    abort_conv_a: assert property (xfer_abort |=> conv_start
        && s_reg.st == ST_IDLE)
        else $error("abort did not start a conversion");
    addr_keep_a: assert property (
        xfer_abort and (s_reg.bits < ADDR_LAST) |=> $stable(chan_addr))
        else $error("partial address stored on abort");
    pu_low_a: assert property (s_reg.st != ST_POR && !sck_s
        && !s_next.restore |=> !sck_pu_en)
        else $error("pull-up on while clock pin low");
    por_pu_a: assert property (s_reg.st == ST_POR |=> sck_pu_en)
        else $error("pull-up off during power-on reset");
    test_delay_a: assert property (s_reg.st == ST_STATUS
        && s_reg.int_mode && !cs_s && !converting
        && s_reg.tmr == test_cyc - 32'd1 |=> sck_out
        && s_reg.st == ST_XFER)
        else $error("first rising edge not at test delay");
    sleep_keep_a: assert property (s_reg.st == ST_STATUS && cs_s
        && !converting |=> $stable(s_reg.sreg) && s_reg.st == ST_IDLE)
        else $error("result lost on early select rise");
    cont_conv_a: assert property (s_reg.st == ST_CONT_CONV
        && s_reg.busy ##1 s_reg.busy |-> sck_out && sdo_out)
        else $error("continuous mode pins not high while converting");
endmodule : acst_top
`default_nettype wire

// ---- verif/acst_host.sv ----
/*
 host controller model on the far side of the converter serial link.
 assumes the bench resolves the clock pin from every driver.
*/
`timescale 1ns/1ps
`default_nettype none
module acst_host
(
    input wire logic clk_sys, // system clock
    input wire logic sck_pin, // resolved clock pin level
    input wire logic sdo_pin, // data out pin
    output logic cs_n, // chip select
    output logic sck_drv, // host clock value
    output logic sck_drv_en, // host drives clock pin
    output logic sdi // serial data in
);
    initial
    begin
        cs_n = 1'b1;
        sck_drv = 1'b0;
        sck_drv_en = 1'b0;
        sdi = 1'b0;
    end

    task automatic set_cs(input logic v);
        @(posedge clk_sys);
        #1 cs_n = v;
    endtask : set_cs

    // pin level wait, bounded to 200 cycles
    task automatic wait_pin(input logic lvl, inout int n);
        int k;
        k = 0;
        while (sck_pin !== lvl && k < 200)
        begin
            @(posedge clk_sys);
            #1 k++;
        end
        n += k;
    endtask : wait_pin

    task automatic xfer(input logic ext, input logic fall,
        input logic [7:0] addr, input int nrise,
        output logic [18:0] bits, output int first);
        int i;
        int n;
        bits = '0;
        first = 0;
        n = 0;
        if (ext)
        begin
            sck_drv_en = 1'b1;
            repeat (4) @(posedge clk_sys);
        end
        if (fall)
            set_cs(1'b0);
        if (ext)
        begin
            repeat (6) @(posedge clk_sys);
            #1;
        end
        for (i = 0; i < nrise; i++)
        begin
            if (ext)
            begin
                sck_drv = 1'b0;
                sdi = (i < 8) ? addr[7-i] : 1'b0;
                #24 sck_drv = 1'b1;
                bits[18-i] = sdo_pin;
                #24;
            end
            else
            begin
                wait_pin(1'b0, n);
                sdi = (i < 8) ? addr[7-i] : 1'b0;
                wait_pin(1'b1, n);
                bits[18-i] = sdo_pin;
                if (i == 0)
                    first = n;
            end
        end
        if (ext)
            sck_drv = 1'b0;
        else if (nrise < 19)
            cs_n = 1'b1;
    endtask : xfer
endmodule : acst_host
`default_nettype wire

// ---- verif/acst_top_bench.sv ----
/*
 self-checking bench of the converter serial sequencer.
 assumes acst_top and acst_host; the converter core is modelled here.
*/
`timescale 1ns/1ps
`default_nettype none
module acst_top_bench;
    localparam int POR = 50;
    localparam int TST = 20;
    localparam int CONV = 40;
    // 3.6 periods of a 300 kHz oscillator in 5 ns cycles
    localparam int EXT_TST = 2400;
    localparam logic [17:0] RES = 18'h2d3a5;
    logic clk_sys, reset, sck_pin, sdo_pin, cs_n, sck_drv, sck_drv_en, sdi;
    logic sck_out, sck_oe_n, sck_pu_en, sdo_out, sdo_oe_n;
    logic conv_done, conv_start, ext_osc;
    logic [17:0] conv_res;
    logic [7:0] chan_addr;
    logic [18:0] bits;
    int busy_cnt, starts, err_count, cmp_count, first, s0;

    // ---------------------------------------------
    // pins and converter core
    // ---------------------------------------------
    // pull-up off leaves the pin low
    assign sck_pin = !sck_oe_n ? sck_out : sck_drv_en ? sck_drv : sck_pu_en;
    assign sdo_pin = sdo_oe_n ? 1'bz : sdo_out;

    always @(posedge clk_sys)
    begin
        conv_done <= 1'b0;
        if (reset)
            busy_cnt <= 0;
        else if (conv_start === 1'b1)
        begin
            busy_cnt <= CONV;
            starts <= starts + 1;
        end
        else if (busy_cnt == 1)
        begin
            busy_cnt <= 0;
            conv_done <= 1'b1;
        end
        else if (busy_cnt != 0)
            busy_cnt <= busy_cnt - 1;
    end

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    acst_top #(.POR_CYC(POR), .TEST_CYC(TST), .SCK_HALF(4)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .cs_n(cs_n), .sck_in(sck_pin),
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sck_pu_en(sck_pu_en),
        .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
        .ext_osc(ext_osc), .conv_done(conv_done), .conv_result(conv_res),
        .conv_start(conv_start), .chan_addr(chan_addr));

    acst_host u_host (
        .clk_sys(clk_sys), .sck_pin(sck_pin), .sdo_pin(sdo_pin),
        .cs_n(cs_n), .sck_drv(sck_drv), .sck_drv_en(sck_drv_en), .sdi(sdi));

    // ---------------------------------------------
    // compare and closing
    // ---------------------------------------------
    task automatic chk(input logic [18:0] got, input logic [18:0] exp,
        input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s got %b", $time, what, got);
        end
    endtask : chkb

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cycles

    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_por();
        cycles(4);
        chkb(sdo_oe_n, 1'b1, "sdo released in reset");
        chkb(sck_pu_en, 1'b1, "pull-up in reset");
        reset = 1'b0;
        cycles(POR + 8);
        chkb(sck_pu_en, 1'b1, "pull-up after power-on");
        cycles(CONV + 12);
    endtask : t_por

    task automatic t_status();
        s0 = starts;
        u_host.set_cs(1'b0);
        cycles(6);
        chkb(sdo_pin, 1'b0, "done flag");
        chkb(sck_pin, 1'b0, "clock driven low");
        chkb(sck_pu_en, 1'b0, "pull-up off while low");
        u_host.set_cs(1'b1);
        cycles(5);
        chkb(sck_pu_en, 1'b1, "pull-up restored");
        chkb(sck_pin, 1'b1, "clock pulled up");
        chkb(sdo_pin, 1'bz, "sdo released");
        chkb(starts == s0, 1'b1, "result held, no conversion");
    endtask : t_status

    task automatic t_single();
        s0 = starts;
        u_host.xfer(1'b0, 1'b1, 8'ha5, 19, bits, first);
        chkb(first >= TST && first <= TST + 8, 1'b1, "test delay");
        chk(bits, {1'b0, RES}, "internal clock data");
        cycles(8);
        chkb(sdo_pin, 1'b1, "busy after last edge");
        chkb(sck_pin, 1'b1, "clock stays high");
        chkb(starts == s0 + 1, 1'b1, "conversion started");
        chk(19'(chan_addr), 19'h000a5, "address loaded");
        u_host.set_cs(1'b1);
        cycles(CONV + 12);
    endtask : t_single

    task automatic t_abort();
        s0 = starts;
        u_host.xfer(1'b0, 1'b1, 8'h3c, 4, bits, first);
        cycles(6);
        chkb(starts == s0 + 1, 1'b1, "abort starts conversion");
        chk(19'(chan_addr), 19'h000a5, "old address kept");
        chk(bits >> 15, {1'b0, RES} >> 15, "partial data");
        cycles(CONV + 12);
    endtask : t_abort

    task automatic t_slow_osc();
        s0 = starts;
        ext_osc = 1'b1;
        u_host.set_cs(1'b0);
        cycles(EXT_TST - 8);
        chkb(sck_pin, 1'b0, "no early rise, slow osc");
        cycles(12);
        chkb(sck_pin, 1'b1, "rise after slow osc delay");
        u_host.cs_n = 1'b1;
        cycles(6);
        chkb(starts == s0 + 1, 1'b1, "abort after slow delay");
        ext_osc = 1'b0;
        cycles(CONV + 12);
    endtask : t_slow_osc

    task automatic t_external();
        s0 = starts;
        u_host.xfer(1'b1, 1'b1, 8'h5a, 19, bits, first);
        chk(bits, {1'b0, RES}, "external clock data");
        cycles(8);
        chkb(sdo_pin, 1'b1, "busy after last fall");
        chkb(starts == s0 + 1, 1'b1, "conversion started");
        chk(19'(chan_addr), 19'h0005a, "address loaded");
        u_host.set_cs(1'b1);
        u_host.sck_drv_en = 1'b0;
    endtask : t_external

    task automatic t_cont();
        u_host.set_cs(1'b0);
        reset = 1'b1;
        cycles(4);
        reset = 1'b0;
        cycles(POR + 10);
        chkb(sck_pin, 1'b1, "clock high converting");
        chkb(sdo_pin, 1'b1, "sdo high converting");
        s0 = starts;
        u_host.xfer(1'b0, 1'b0, 8'h81, 19, bits, first);
        chk(bits, {1'b0, RES}, "continuous data");
        cycles(8);
        chkb(sdo_pin, 1'b1, "busy after last edge");
        chkb(sck_pin, 1'b1, "clock high again");
        chkb(starts == s0 + 1, 1'b1, "conversion restarted");
        chk(19'(chan_addr), 19'h00081, "address loaded");
    endtask : t_cont

    initial
    begin
        reset = 1'b1;
        conv_done = 1'b0;
        ext_osc = 1'b0;
        conv_res = RES;
        busy_cnt = 0;
        starts = 0;
        err_count = 0;
        cmp_count = 0;
        t_por();
        t_status();
        t_single();
        t_abort();
        t_slow_osc();
        t_external();
        t_cont();
        end_sim();
    end

    initial
    begin
        #60000;
        err_count++;
        end_sim();
    end
endmodule : acst_top_bench
`default_nettype wire
